// ===== verilog/adcc_top.sv
/*
  adcc_top: control and result registers of a 10-bit sar converter,
  APB slave, sequencing of acquisition, conversion and discharge.
  assumes: analog front end answers cmp_high combinationally; trigger
  is a one-cycle pulse from the capture/compare unit.
*/
`timescale 1ns/1ps
module adcc_top
  import adcc_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        special_trigger,
  input  wire logic        cmp_high,
  output logic             converter_power,
  output logic [3:0]       channel_select,
  output logic             channel_valid,
  output logic [1:0]       positive_reference_select,
  output logic [1:0]       negative_reference_select,
  output logic             hold_capacitor,
  output logic             hold_discharge,
  output logic             sample_hold,
  output logic             conversion_complete_flag
);
  import adcc_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  logic [7:0]  ctrl0_reg;
  logic [7:0]  ctrl1_reg;
  logic [7:0]  ctrl2_reg;
  logic [7:0]  resh_reg;
  logic [7:0]  resl_reg;
  logic        flag_reg;
  logic        go_reg;
  adcc_state_t state_reg;
  adcc_state_t state_next;
  logic [4:0]  cnt_reg;
  logic [4:0]  cnt_next;

  logic        wr_en;
  logic        rd_en;
  logic        hit0;
  logic        hit1;
  logic        hit2;
  logic        hith;
  logic        hitl;
  logic        hits;
  logic        mapped;
  logic        lane0;
  logic        ctrl0_wr;
  logic        en_next;
  logic        sw_go_set;
  logic        sw_go_clr;
  logic        go_set;
  logic        enabled;
  logic        frc_sel;
  logic        tick;
  logic        tick_clr;
  logic        sar_start;
  logic        sar_last;
  logic [9:0]  sar_value;
  logic [9:0]  sar_filled;
  logic [4:0]  acq_periods;
  logic        finish;
  logic        abort;
  logic        load;
  logic [9:0]  load_value;
  logic        fmt_right;
  logic [7:0]  load_h;
  logic [7:0]  load_l;
  logic [7:0]  rd_byte;

  ////////////////////////////////////////////////////////////////////////
  // apb decode; zero wait states, unmapped addresses answer pslverr
  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && !pwrite;
  assign hit0    = (paddr == ADCC_OFF_CTRL0);
  assign hit1    = (paddr == ADCC_OFF_CTRL1);
  assign hit2    = (paddr == ADCC_OFF_CTRL2);
  assign hith    = (paddr == ADCC_OFF_RESH);
  assign hitl    = (paddr == ADCC_OFF_RESL);
  assign hits    = (paddr == ADCC_OFF_STATUS);
  assign mapped  = hit0 || hit1 || hit2 || hith || hitl || hits;
  assign lane0   = pstrb[0];
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;

  assign enabled   = ctrl0_reg[ADCC_EN_BIT];
  assign frc_sel   = (ctrl2_reg[ADCC_CLK_LSB +: 2] == 2'b11);
  assign fmt_right = ctrl2_reg[ADCC_FMT_BIT];

  assign sw_go_set = wr_en && hit0 && lane0 && pwdata[ADCC_GO_BIT];
  assign sw_go_clr = wr_en && hit0 && lane0 && !pwdata[ADCC_GO_BIT];
  // enable as it stands after this edge, so enable and start may share a write
  assign ctrl0_wr  = wr_en && hit0 && lane0;
  assign en_next   = ctrl0_wr ? pwdata[ADCC_EN_BIT] : enabled;
  // start only counts while powered and idle
  assign go_set    = (sw_go_set || special_trigger) && en_next
                     && (state_reg == ADCC_IDLE) && !go_reg;

  ////////////////////////////////////////////////////////////////////////
  // acquisition length in conversion clock periods
  always_comb begin
    case (ctrl2_reg[ADCC_ACQ_LSB +: 3])
      3'h0:    acq_periods = 5'd0;
      3'h1:    acq_periods = 5'd2;
      3'h2:    acq_periods = 5'd4;
      3'h3:    acq_periods = 5'd6;
      3'h4:    acq_periods = 5'd8;
      3'h5:    acq_periods = 5'd12;
      3'h6:    acq_periods = 5'd16;
      default: acq_periods = 5'd20;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // abort: software clears start, or power removed mid-cycle
  // power off aborts at the write edge, so the front end never runs unpowered
  assign abort  = go_reg && (sw_go_clr || !en_next);
  assign finish = (state_reg == ADCC_CONV) && tick && sar_last && !abort;
  assign load   = finish || (abort && (state_reg == ADCC_CONV));
  // lsb is decided by the comparator in the finishing cycle itself
  assign load_value = finish ? {sar_value[9:1], cmp_high} : sar_filled;

  assign load_h = fmt_right ? {6'h00, load_value[9:8]}
                            : load_value[9:2];
  assign load_l = fmt_right ? load_value[7:0]
                            : {load_value[1:0], 6'h00};

  // restart on abort too, so the wait after it is two full periods
  assign tick_clr  = go_set || abort;
  assign sar_start = (state_next == ADCC_CONV) && (state_reg != ADCC_CONV);

  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    case (state_reg)
      ADCC_IDLE: begin
        if (go_set) begin
          cnt_next = 5'(ADCC_INSTR_CYC);
          if (frc_sel) begin
            state_next = ADCC_HOLDOFF;
          end else if (acq_periods != 5'd0) begin
            state_next = ADCC_ACQ;
            cnt_next   = acq_periods;
          end else begin
            state_next = ADCC_CONV;
          end
        end
      end
      ADCC_HOLDOFF: begin
        cnt_next = cnt_reg - 5'd1;
        if (cnt_reg == 5'd1) begin
          state_next = (acq_periods != 5'd0) ? ADCC_ACQ : ADCC_CONV;
          cnt_next   = acq_periods;
        end
      end
      ADCC_ACQ: begin
        if (tick) begin
          cnt_next = cnt_reg - 5'd1;
          if (cnt_reg == 5'd1) begin
            state_next = ADCC_CONV;
          end
        end
      end
      ADCC_CONV: begin
        if (finish) begin
          state_next = ADCC_DISCH;
          cnt_next   = 5'(ADCC_POST_WAIT);
        end
      end
      ADCC_DISCH: begin
        if (tick) begin
          cnt_next = cnt_reg - 5'd1;
          if (cnt_reg == 5'd1) begin
            state_next = ADCC_IDLE;
          end
        end
      end
      default: begin
        state_next = ADCC_IDLE;
      end
    endcase
    if (abort && (state_reg != ADCC_DISCH) && (state_reg != ADCC_IDLE)) begin
      state_next = ADCC_DISCH;
      cnt_next   = 5'(ADCC_POST_WAIT);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  adcc_tick u_tick (
    .pclk    (pclk),
    .presetn (presetn),
    .clr     (tick_clr),
    .sel     (ctrl2_reg[ADCC_CLK_LSB +: 3]),
    .tick    (tick)
  );

  adcc_sar u_sar (
    .pclk     (pclk),
    .presetn  (presetn),
    .start    (sar_start),
    .step     (tick && (state_reg == ADCC_CONV)),
    .cmp_high (cmp_high),
    .value    (sar_value),
    .filled   (sar_filled),
    .last     (sar_last)
  );

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ADCC_IDLE;
      cnt_reg   <= 5'd0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
    end
  end

  // start bit: set wins over hardware clear only when new start allowed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      go_reg <= 1'b0;
    end else if (go_set) begin
      go_reg <= 1'b1;
    end else if (finish || abort) begin
      go_reg <= 1'b0;
    end
  end

  // flag: completion sets, write of zero clears; set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_reg <= 1'b0;
    end else if (finish) begin
      flag_reg <= 1'b1;
    end else if (wr_en && hits && lane0 && !pwdata[ADCC_FLAG_BIT]) begin
      flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl0_reg <= ADCC_CTRL_RESET;
      ctrl1_reg <= ADCC_CTRL_RESET;
      ctrl2_reg <= ADCC_CTRL_RESET;
    end else if (wr_en && lane0) begin
      if (hit0) ctrl0_reg <= pwdata[7:0] & ADCC_CTRL0_MASK;
      if (hit1) ctrl1_reg <= pwdata[7:0] & ADCC_CTRL1_MASK;
      if (hit2) ctrl2_reg <= pwdata[7:0] & ADCC_CTRL2_MASK;
    end
  end

  // results: hardware load wins over software write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      resh_reg <= ADCC_RES_RESET;
      resl_reg <= ADCC_RES_RESET;
    end else if (load) begin
      resh_reg <= load_h;
      resl_reg <= load_l;
    end else if (wr_en && lane0) begin
      if (hith) resh_reg <= pwdata[7:0];
      if (hitl) resl_reg <= pwdata[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // start bit reads live; stored copy in ctrl0 bit 1 is masked out
  assign rd_byte = hit0 ? ((ctrl0_reg & ~8'h02) | {6'h00, go_reg, 1'b0}) :
                   hit1 ? ctrl1_reg :
                   hit2 ? ctrl2_reg :
                   hith ? resh_reg :
                   hitl ? resl_reg :
                   hits ? {7'h00, flag_reg} : 8'h00;
  assign prdata = rd_en ? {24'h000000, rd_byte} : 32'h00000000;

  ////////////////////////////////////////////////////////////////////////
  assign converter_power           = enabled;
  assign channel_select            = ctrl0_reg[ADCC_CHS_LSB +: 4];
  assign channel_valid             = ((channel_select >= ADCC_CH_FIRST) &&
                                      (channel_select <= ADCC_CH_LAST)) ||
                                     (channel_select == ADCC_CH_DAC) ||
                                     (channel_select == ADCC_CH_FVR);
  assign positive_reference_select = ctrl1_reg[ADCC_PREF_LSB +: 2];
  assign negative_reference_select = ctrl1_reg[ADCC_NREF_LSB +: 2];
  // reconnected only outside conversion and discharge
  assign hold_capacitor  = enabled && ((state_reg == ADCC_IDLE) ||
                                       (state_reg == ADCC_HOLDOFF) ||
                                       (state_reg == ADCC_ACQ));
  assign hold_discharge  = (state_reg == ADCC_DISCH);
  assign sample_hold     = (state_reg == ADCC_CONV);
  assign conversion_complete_flag = flag_reg;
endmodule // adcc_top

// ===== verilog/adcc_pkg.sv
/*
  adcc_pkg: register offsets, field positions, reset values and timing
  constants for the converter control block.
  assumes: APB slave with 32-bit data, one aligned word per register.
*/
package adcc_pkg;

  ////////////////////////////////////////////////////////////////////////
  localparam logic [7:0] ADCC_OFF_CTRL0  = 8'h00;
  localparam logic [7:0] ADCC_OFF_CTRL1  = 8'h04;
  localparam logic [7:0] ADCC_OFF_CTRL2  = 8'h08;
  localparam logic [7:0] ADCC_OFF_RESH   = 8'h0C;
  localparam logic [7:0] ADCC_OFF_RESL   = 8'h10;
  localparam logic [7:0] ADCC_OFF_STATUS = 8'h14;

  ////////////////////////////////////////////////////////////////////////
  localparam int ADCC_EN_BIT       = 0;
  localparam int ADCC_GO_BIT       = 1;
  localparam int ADCC_CHS_LSB      = 2;
  localparam int ADCC_NREF_LSB     = 0;
  localparam int ADCC_PREF_LSB     = 2;
  localparam int ADCC_CLK_LSB      = 0;
  localparam int ADCC_ACQ_LSB      = 3;
  localparam int ADCC_FMT_BIT      = 7;
  localparam int ADCC_FLAG_BIT     = 0;

  localparam logic [7:0] ADCC_CTRL0_MASK = 8'h3F;
  localparam logic [7:0] ADCC_CTRL1_MASK = 8'h0F;
  localparam logic [7:0] ADCC_CTRL2_MASK = 8'hBF;
  localparam logic [7:0] ADCC_CTRL_RESET = 8'h00;
  localparam logic [7:0] ADCC_RES_RESET  = 8'h00;

  ////////////////////////////////////////////////////////////////////////
  localparam int ADCC_RES_BITS     = 10;
  localparam int ADCC_POST_WAIT    = 2;
  // frc period at 600 kHz nominal, in ns, turned into pclk cycles
  localparam int ADCC_FRC_NS       = 1667;
  localparam int ADCC_CLK_NS       = 5;
  localparam int ADCC_FRC_CYC      = ADCC_FRC_NS / ADCC_CLK_NS;
  // one instruction cycle, taken as four pclk periods
  localparam int ADCC_INSTR_NS     = 20;
  localparam int ADCC_INSTR_CYC    = (ADCC_INSTR_NS + ADCC_CLK_NS - 1) / ADCC_CLK_NS;

  localparam logic [3:0] ADCC_CH_FIRST = 4'h3;
  localparam logic [3:0] ADCC_CH_LAST  = 4'hB;
  localparam logic [3:0] ADCC_CH_DAC   = 4'hE;
  localparam logic [3:0] ADCC_CH_FVR   = 4'hF;

  typedef enum logic [2:0] {
    ADCC_IDLE, ADCC_HOLDOFF, ADCC_ACQ, ADCC_CONV, ADCC_DISCH
  } adcc_state_t;

endpackage

// ===== verilog/adcc_tick.sv
/*
  adcc_tick: conversion clock period generator, one pulse per period.
  assumes: pclk at 200 MHz; restarted by clr at each conversion start.
*/
`timescale 1ns/1ps
module adcc_tick
  import adcc_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       clr,
  input  wire logic [2:0] sel,
  output logic            tick
);
  logic [10:0] cnt_reg;
  logic [10:0] limit;

  // divide ratio per select code; x11 is the internal oscillator
  always_comb begin
    case (sel)
      3'h0:    limit = 11'h001;
      3'h1:    limit = 11'h007;
      3'h2:    limit = 11'h01F;
      3'h4:    limit = 11'h003;
      3'h5:    limit = 11'h00F;
      3'h6:    limit = 11'h03F;
      default: limit = 11'(ADCC_FRC_CYC - 1);
    endcase
  end

  assign tick = (cnt_reg >= limit);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 11'h000;
    end else if (clr || tick) begin
      cnt_reg <= 11'h000;
    end else begin
      cnt_reg <= cnt_reg + 11'h001;
    end
  end
endmodule // adcc_tick

// ===== verilog/adcc_sar.sv
/*
  adcc_sar: successive-approximation register, one bit per tick, msb first.
  assumes: comparator input is valid when step is pulsed.
*/
`timescale 1ns/1ps
module adcc_sar
  import adcc_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       start,
  input  wire logic       step,
  input  wire logic       cmp_high,
  output logic [9:0]      value,
  output logic [9:0]      filled,
  output logic            last
);
  logic [9:0] val_reg;
  logic [9:0] bit_reg;
  logic [9:0] lowmask;
  logic       lastbit;

  assign value   = val_reg;
  assign last    = bit_reg[0];
  assign lowmask = bit_reg - 10'h001;
  // unconverted bits copy the last resolved bit
  assign lastbit = |(val_reg & (bit_reg << 1)) ;
  assign filled  = bit_reg[9] ? 10'h000 :
                   ((val_reg & ~lowmask & ~bit_reg) |
                    ({10{lastbit}} & (lowmask | bit_reg)));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      val_reg <= 10'h000;
      bit_reg <= 10'h000;
    end else if (start) begin
      val_reg <= 10'h200;
      bit_reg <= 10'h200;
    end else if (step && (bit_reg != 10'h000)) begin
      val_reg <= (cmp_high ? val_reg : (val_reg & ~bit_reg)) | (bit_reg >> 1);
      bit_reg <= bit_reg >> 1;
    end
  end
endmodule // adcc_sar

// ===== verification/adcc_top_assertions.sv
/* adcc_top_assertions: port-level checks of the converter control block.
   assumes: bound into adcc_top, one pclk domain, APB with pready tied high. */
`timescale 1ns/1ps
module adcc_top_assertions
  import adcc_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic        pslverr,
  input wire logic        converter_power,
  input wire logic [3:0]  channel_select,
  input wire logic        channel_valid,
  input wire logic [1:0]  positive_reference_select,
  input wire logic [1:0]  negative_reference_select,
  input wire logic        hold_capacitor,
  input wire logic        hold_discharge,
  input wire logic        sample_hold
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic wr_ok = psel && penable && pwrite && pstrb[0];
  wire logic wr0   = wr_ok && paddr == ADCC_OFF_CTRL0;
  wire logic wr1   = wr_ok && paddr == ADCC_OFF_CTRL1;
  wire logic legal = channel_select inside {[ADCC_CH_FIRST:ADCC_CH_LAST], ADCC_CH_DAC, ADCC_CH_FVR};
  //////////////////////////////////////////////////////////////////////////
  a_power_tracks: assert property (wr0 |=> converter_power == $past(pwdata[0]))
    else $error("enable output does not follow the written bit");
  a_off_quiet: assert property (!converter_power |-> !sample_hold && !hold_capacitor)
    else $error("front end active while converter is off");
  a_channel_tracks: assert property (wr0 |=> channel_select == $past(pwdata[5:2]))
    else $error("channel output does not follow the written field");
  a_channel_legal: assert property (channel_valid |-> legal)
    else $error("reserved channel code flagged as valid");
  a_refs_track: assert property (wr1 |=> {positive_reference_select,
    negative_reference_select} == $past(pwdata[3:0]))
    else $error("reference outputs do not follow the written fields");
  a_hold_apart: assert property (!(hold_capacitor && (sample_hold || hold_discharge)))
    else $error("hold capacitor connected outside acquisition");
  a_discharge_after: assert property ($fell(sample_hold) && converter_power
    |-> ##[0:1] hold_discharge)
    else $error("no discharge after conversion");
  a_discharge_span: assert property ($rose(hold_discharge) |-> hold_discharge[*2])
    else $error("discharge wait too short");
  a_unmapped_err: assert property (psel && penable && paddr > ADCC_OFF_STATUS |-> pslverr)
    else $error("unmapped access not refused");
  cover property ($fell(sample_hold));
  cover property (wr0 && pwdata[1:0] == 2'b11);
  cover property ($rose(hold_discharge));
endmodule // adcc_top_assertions

bind adcc_top adcc_top_assertions i_adcc_top_assertions (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pstrb, .pslverr, .converter_power, .channel_select,
  .channel_valid, .positive_reference_select, .negative_reference_select, .hold_capacitor,
  .hold_discharge, .sample_hold);

// ===== verification/adcc_front_end.sv
/* adcc_front_end: behavioural comparator side of the converter.
   assumes: the bench sets level_high, the answer given to every trial bit. */
`timescale 1ns/1ps
module adcc_front_end
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sample_hold,
  input wire logic level_high,
  output logic     cmp_high
);
  logic noise_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      noise_reg <= 1'b0;
    end else begin
      noise_reg <= ~noise_reg;
    end
  end
  // unsettled outside a conversion, so it wanders instead of holding
  assign cmp_high = sample_hold ? level_high : noise_reg;
endmodule // adcc_front_end

// ===== verification/adcc_top_bench.sv
/* adcc_top_bench: self-checking bench for the converter control block.
   assumes: adcc_front_end on the comparator side, APB master driven here. */
`timescale 1ns/1ps
module adcc_top_bench;
  import adcc_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, special_trigger, level_high, clr;
  logic        pready, pslverr, cmp_high, converter_power, channel_valid, hold_capacitor;
  logic        hold_discharge, sample_hold, conversion_complete_flag, rd_err, seen;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd_data;
  logic [3:0]  pstrb, channel_select;
  logic [1:0]  positive_reference_select, negative_reference_select;
  int          miscompares, compares, sh_cnt, pre_cnt, pre0, pre, sh;

  adcc_top i_adcc_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .special_trigger, .cmp_high, .converter_power,
    .channel_select, .channel_valid, .positive_reference_select,
    .negative_reference_select, .hold_capacitor, .hold_discharge, .sample_hold,
    .conversion_complete_flag);
  adcc_front_end i_adcc_front_end (.pclk, .presetn, .sample_hold, .level_high, .cmp_high);

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (clr) begin
      sh_cnt <= 0;
      pre_cnt <= 0;
      seen <= 1'b0;
    end else if (sample_hold) begin
      sh_cnt <= sh_cnt + 1;
      seen <= 1'b1;
    end else if (!seen) begin
      pre_cnt <= pre_cnt + 1;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd_data = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, exp, rd_data);
  endtask
  task automatic wait_done();
    int n;
    n = 0;
    do begin
      apb(1'b0, ADCC_OFF_CTRL0, 32'h0);
      n++;
    end while (rd_data[ADCC_GO_BIT] !== 1'b0 && n < 3000);
    while (hold_discharge !== 1'b0 && n < 3000) begin
      n++;
      @(posedge pclk);
    end
    chk("conversion end in time", 32'h1, {31'h0, n < 3000});
    chk("start bit at end", 32'h0, {31'h0, rd_data[ADCC_GO_BIT]});
  endtask
  task automatic conv(input logic [7:0] c2);
    apb(1'b1, ADCC_OFF_CTRL2, {24'h0, c2});
    clr <= 1'b1;
    @(posedge pclk);
    clr <= 1'b0;
    apb(1'b1, ADCC_OFF_CTRL0, 32'h13);
    rd(ADCC_OFF_CTRL0, 32'h13, "start bit while busy");
    wait_done();
    pre = pre_cnt;
    sh = sh_cnt;
  endtask
  //////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    for (int i = 0; i < 6; i++) rd(8'(4 * i), 32'h0, "reset value");
    apb(1'b0, 8'h18, 32'h0);
    chk("unmapped refusal", 32'h1, {31'h0, rd_err});
  endtask
  task automatic t_fields();
    apb(1'b1, ADCC_OFF_CTRL0, 32'hFD);
    rd(ADCC_OFF_CTRL0, 32'h3D, "control 0 unused bits");
    apb(1'b1, ADCC_OFF_CTRL1, 32'hFF);
    rd(ADCC_OFF_CTRL1, 32'h0F, "control 1 unused bits");
    apb(1'b1, ADCC_OFF_CTRL2, 32'hFF);
    rd(ADCC_OFF_CTRL2, 32'hBF, "control 2 unused bits");
    apb(1'b1, ADCC_OFF_CTRL0, 32'h02);
    rd(ADCC_OFF_CTRL0, 32'h00, "start while disabled");
  endtask
  task automatic t_ports();
    for (int i = 0; i < 16; i++) begin
      apb(1'b1, ADCC_OFF_CTRL1, 32'(i));
      chk("references", 32'(i), {28'h0, positive_reference_select,
        negative_reference_select});
      apb(1'b1, ADCC_OFF_CTRL0, 32'(i << 2));
      chk("channel", 32'(i), {28'h0, channel_select});
      chk("channel legal", 32'((i >= 3 && i <= 11) || i >= 14), {31'h0, channel_valid});
    end
  endtask
  task automatic t_formats();
    conv(8'h80);
    rd(ADCC_OFF_RESH, 32'h03, "right result high");
    rd(ADCC_OFF_RESL, 32'hFF, "right result low");
    rd(ADCC_OFF_STATUS, 32'h01, "complete flag");
    chk("complete flag output", 32'h1, {31'h0, conversion_complete_flag});
    apb(1'b1, ADCC_OFF_STATUS, 32'h0);
    rd(ADCC_OFF_STATUS, 32'h00, "flag cleared");
    conv(8'h00);
    rd(ADCC_OFF_RESH, 32'hFF, "left result high");
    rd(ADCC_OFF_RESL, 32'hC0, "left result low");
  endtask
  task automatic t_timing();
    int acq[8] = '{0, 2, 4, 6, 8, 12, 16, 20};
    int dv[8] = '{2, 8, 32, ADCC_FRC_CYC, 4, 16, 64, ADCC_FRC_CYC};
    conv(8'h80);
    pre0 = pre;
    for (int c = 1; c < 8; c++) begin
      conv(8'h80 | 8'(c << 3));
      chk("acquisition cycles", 32'(2 * acq[c]), 32'(pre - pre0));
    end
    for (int c = 0; c < 8; c++) begin
      conv(8'h80 | 8'(c));
      if (c == 3 || c == 7) chk("oscillator holdoff", 1, pre >= pre0 + ADCC_INSTR_CYC);
      chk("conversion span", 1, sh >= 9 * dv[c] && sh <= 11 * dv[c]);
    end
  endtask
  task automatic t_abort();
    int n;
    logic [9:0] r;
    n = 0;
    apb(1'b1, ADCC_OFF_CTRL2, 32'h86);
    apb(1'b1, ADCC_OFF_CTRL0, 32'h13);
    while (sample_hold !== 1'b1 && n < 500) begin
      n++;
      @(posedge pclk);
    end
    chk("conversion began", 32'h1, {31'h0, n < 500});
    repeat (224) @(posedge pclk);
    level_high <= 1'b0;
    repeat (126) @(posedge pclk);
    apb(1'b1, ADCC_OFF_CTRL0, 32'h11);
    n = 0;
    while (hold_capacitor !== 1'b1 && n < 500) begin
      n++;
      @(posedge pclk);
    end
    chk("reconnect delay", 1, n >= 60 && n <= 192);
    apb(1'b0, ADCC_OFF_RESH, 32'h0);
    r[9:8] = rd_data[1:0];
    apb(1'b0, ADCC_OFF_RESL, 32'h0);
    r[7:0] = rd_data[7:0];
    chk("partial result", 1, r === 10'h380 || r === 10'h3C0);
    rd(ADCC_OFF_CTRL0, 32'h11, "start after abort");
    level_high <= 1'b1;
  endtask
  task automatic t_trigger();
    apb(1'b1, ADCC_OFF_CTRL2, 32'h80);
    special_trigger <= 1'b1;
    @(posedge pclk);
    special_trigger <= 1'b0;
    rd(ADCC_OFF_CTRL0, 32'h13, "hardware start");
    wait_done();
  endtask
  //////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge pclk);
    miscompares++;
    conclude();
  end
  initial begin
    {presetn, psel, penable, pwrite, special_trigger, clr} = '0;
    {paddr, pwdata} = '0;
    pstrb = 4'hF;
    level_high = 1'b1;
    miscompares = 0;
    compares = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_fields();
    t_ports();
    t_formats();
    t_timing();
    t_abort();
    t_trigger();
    conclude();
  end
endmodule // adcc_top_bench
